/* File: hw/dps_pkg.sv */
// Constants shared by the input power path selector and its testbench.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package dps_pkg;

   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam logic [7:0] DPS_REG_PATH_CTRL    = 8'h13;  // input_path_control
   localparam int         DPS_BIT_EN_ONE       = 7;      // path_one_enable
   localparam int         DPS_BIT_EN_TWO       = 6;      // path_two_enable
   localparam int         DPS_BIT_ST_ONE       = 5;      // path_one_closed_status, read only
   localparam int         DPS_BIT_ST_TWO       = 4;      // path_two_closed_status, read only
   localparam int         DPS_BIT_ALL_DIS      = 0;      // all_paths_disable
   localparam logic       DPS_RST_ENABLE       = 1'b0;
   localparam logic       DPS_RST_ALL_DIS      = 1'b0;
   localparam logic [7:0] DPS_RDATA_IDLE       = 8'h00;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int         DPS_CLK_PERIOD_NS    = 10;
   localparam int         DPS_DET_SETTLE_NS    = 1000;   // Gate pin settle time before sampling
   localparam int         DPS_DET_CYCLES       = (DPS_DET_SETTLE_NS + DPS_CLK_PERIOD_NS - 1) / DPS_CLK_PERIOD_NS;
   localparam int         DPS_DET_CNT_W        = $clog2(DPS_DET_CYCLES + 1);
   localparam int         DPS_SYNC_W           = 8;

   // ***********************************************************
   // Path control states
   // ***********************************************************
   typedef enum logic [2:0] {
      DPS_DETECT,
      DPS_IDLE,
      DPS_ON_ONE,
      DPS_ON_TWO,
      DPS_BREAK
   } dps_state_t;

endpackage : dps_pkg

/* File: hw/dps_sync.sv */
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherency between bits.
`timescale 1ns/10ps
module dps_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         reset_n_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_r <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule : dps_sync

/* File: hw/dps_path_selector.sv */
// Dual input power path selector: gate drive control for two back-to-back FET pairs.
// Assumes comparator and gate pin inputs are asynchronous; register port is on sys_clk_i.
//
// Summary of operation
// - At power-on a gate pin held low means that FET pair is absent.
// - No pairs: status bits 0, all-paths disable 1, both enables locked 0.
// - Only pair one: path two status and enable stay 0.
// - Status bit reads 1 while its pair is closed, 0 while open.
// - All-paths disable set forces every gate off.
// - Enable bit 0 forces its gate off; 1 lets it on when conditions hold.
// - Single pair: a valid input one sets enable one and closes pair one.
// - Both pairs found at power-on: both status bits read 1.
// - Dual mode: the first valid input gets its pair closed autonomously.
// - Simultaneous valid inputs: path one wins, enable one set.
// - A second input arriving while the first conducts stays off.
// - A write setting both enables at once leaves both enables unchanged.
// - On a swap, open old pair, wait converter low, then close new.
// - Both valid and active fails by UV, OV or OC: swap automatically.
// - Autonomous swaps update both enable bits to show the active path.
// - One valid input: writing 00 to enables does not open both pairs.
// - Both inputs present: 00 or all-paths disable opens both pairs.
// - Gate on needs pair fitted, input valid, no disables, converter low.
`timescale 1ns/10ps
module dps_path_selector
   import dps_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Comparators (asynchronous)
   input  wire logic       input_sense_one_present_i,
   input  wire logic       input_sense_one_ov_i,
   input  wire logic       input_sense_two_present_i,
   input  wire logic       input_sense_two_ov_i,
   input  wire logic       converter_input_present_i,
   input  wire logic       input_overcurrent_fault_i,
   // Device-level control from other blocks (same clock)
   input  wire logic       both_gates_disable_i,
   input  wire logic       input_high_impedance_request_i,
   // Gate drive pins
   input  wire logic       gate_drive_one_i,
   output logic            gate_drive_one_o,
   output logic            gate_drive_one_oe_o,
   input  wire logic       gate_drive_two_i,
   output logic            gate_drive_two_o,
   output logic            gate_drive_two_oe_o,
   // Status
   output logic            path_one_closed_status_o,
   output logic            path_two_closed_status_o
);

   // ***********************************************************
   // Input synchronisation
   // ***********************************************************
   logic [DPS_SYNC_W-1:0]  raw_in;
   logic [DPS_SYNC_W-1:0]  syn_in;
   logic                   pres1_s, ov1_s, pres2_s, ov2_s, conv_s, oc_s, pin1_s, pin2_s;

   assign raw_in = {input_sense_one_present_i, input_sense_one_ov_i, input_sense_two_present_i,
                    input_sense_two_ov_i, converter_input_present_i, input_overcurrent_fault_i,
                    gate_drive_one_i, gate_drive_two_i};

   dps_sync #(
      .W         (DPS_SYNC_W)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (raw_in),
      .sync_o    (syn_in)
   );

   assign {pres1_s, ov1_s, pres2_s, ov2_s, conv_s, oc_s, pin1_s, pin2_s} = syn_in;

   // ***********************************************************
   // State
   // ***********************************************************
   dps_state_t                state_r;
   dps_state_t                state_nxt;
   logic [DPS_DET_CNT_W-1:0]  det_cnt_r;
   logic                      det_done;
   logic                      fitted1_r, fitted2_r;
   logic                      en1_r, en2_r, dis_r;
   logic                      en1_nxt, en2_nxt, dis_nxt;
   logic                      v1, v2, v1_d_r, v2_d_r, v1_rise, v2_rise;
   logic                      block, wr_ctrl, w_en1, w_en2, take_en;
   logic                      status_hold_r;

   assign det_done = (state_r != DPS_DETECT);
   assign wr_ctrl  = reg_wr_i && (reg_addr_i == DPS_REG_PATH_CTRL);
   assign w_en1    = reg_wdata_i[DPS_BIT_EN_ONE];
   assign w_en2    = reg_wdata_i[DPS_BIT_EN_TWO];

   // Valid input: pair fitted, above presence and below overvoltage
   assign v1 = fitted1_r && pres1_s && !ov1_s;
   assign v2 = fitted2_r && pres2_s && !ov2_s;
   assign v1_rise = v1 && !v1_d_r;
   assign v2_rise = v2 && !v2_d_r;

   // Anything that forbids every gate
   assign block = dis_r || both_gates_disable_i || input_high_impedance_request_i;

   // Enable field is taken unless both set, or 00 with exactly one valid input
   assign take_en = !(w_en1 && w_en2) &&
                    !(!w_en1 && !w_en2 && (v1 ^ v2));

   // ***********************************************************
   // Fitted pair detection at power-on
   // ***********************************************************
   // The pins are released during detection; a pair that is absent has its
   // pin strapped to ground, so a low level after settling means absent.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         det_cnt_r <= '0;
         fitted1_r <= 1'b0;
         fitted2_r <= 1'b0;
      end
      else if (state_r == DPS_DETECT)
      begin
         det_cnt_r <= det_cnt_r + 1'b1;
         if (det_cnt_r == DPS_DET_CNT_W'(DPS_DET_CYCLES))
         begin
            fitted1_r <= pin1_s;
            fitted2_r <= pin2_s;
         end
      end
   end

   // Edge memory for arrival ordering of the two inputs
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         v1_d_r <= 1'b0;
         v2_d_r <= 1'b0;
      end
      else
      begin
         v1_d_r <= v1;
         v2_d_r <= v2;
      end
   end

   // ***********************************************************
   // Control register next value
   // ***********************************************************
   always_comb
   begin
      en1_nxt = en1_r;
      en2_nxt = en2_r;
      dis_nxt = dis_r;
      if (wr_ctrl)
      begin
         dis_nxt = reg_wdata_i[DPS_BIT_ALL_DIS];
         if (take_en)
         begin
            en1_nxt = w_en1;
            en2_nxt = w_en2;
         end
      end
      // Active source lost with the other still good: swap on our own
      if (state_r == DPS_ON_ONE && v2 && (!v1 || oc_s))
      begin
         en1_nxt = 1'b0;
         en2_nxt = 1'b1;
      end
      else if (state_r == DPS_ON_TWO && v1 && (!v2 || oc_s))
      begin
         en1_nxt = 1'b1;
         en2_nxt = 1'b0;
      end
      // Nothing selected: pick the first arrival, path one on a tie or when alone
      else if (!en1_nxt && !en2_nxt && !dis_nxt && !wr_ctrl)
      begin
         if (v1 && (v1_rise || !v2))
            en1_nxt = 1'b1;
         else if (v2 && (v2_rise || !v1))
            en2_nxt = 1'b1;
      end
      // Disable forces both enables clear
      if (dis_nxt)
      begin
         en1_nxt = 1'b0;
         en2_nxt = 1'b0;
      end
      // Absent pairs lock their enables low and no pair at all locks disable high
      en1_nxt = en1_nxt && fitted1_r;
      en2_nxt = en2_nxt && fitted2_r;
      if (!fitted1_r && !fitted2_r)
         dis_nxt = 1'b1;
   end

   // Control register; untouched until detection has settled the lock-outs
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         en1_r <= DPS_RST_ENABLE;
         en2_r <= DPS_RST_ENABLE;
         dis_r <= DPS_RST_ALL_DIS;
      end
      else if (det_done)
      begin
         en1_r <= en1_nxt;
         en2_r <= en2_nxt;
         dis_r <= dis_nxt;
      end
   end

   // ***********************************************************
   // Gate sequencing
   // ***********************************************************
   // Break before make: a pair only closes from IDLE with the converter node
   // below presence, so two sources can never be bridged through the node.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         DPS_DETECT:
            if (det_cnt_r == DPS_DET_CNT_W'(DPS_DET_CYCLES))
               state_nxt = DPS_IDLE;
         DPS_IDLE:
            if (!block && !conv_s)
            begin
               if (en1_r && v1)
                  state_nxt = DPS_ON_ONE;
               else if (en2_r && v2)
                  state_nxt = DPS_ON_TWO;
            end
         DPS_ON_ONE:
            if (block || !en1_r || !v1)
               state_nxt = DPS_BREAK;
         DPS_ON_TWO:
            if (block || !en2_r || !v2)
               state_nxt = DPS_BREAK;
         DPS_BREAK:
            if (!conv_s)
               state_nxt = DPS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_r <= DPS_DETECT;
      else
         state_r <= state_nxt;
   end

   // Gate pins; an absent pair's pin is strapped low and never driven
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         gate_drive_one_o    <= 1'b0;
         gate_drive_two_o    <= 1'b0;
         gate_drive_one_oe_o <= 1'b0;
         gate_drive_two_oe_o <= 1'b0;
      end
      else
      begin
         gate_drive_one_o    <= (state_nxt == DPS_ON_ONE);
         gate_drive_two_o    <= (state_nxt == DPS_ON_TWO);
         gate_drive_one_oe_o <= det_done && fitted1_r;
         gate_drive_two_oe_o <= det_done && fitted2_r;
      end
   end

   // ***********************************************************
   // Status bits
   // ***********************************************************
   // With both pairs found, both bits show 1 until the first gate action;
   // after that each bit tracks its own pair.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         status_hold_r            <= 1'b0;
         path_one_closed_status_o <= 1'b0;
         path_two_closed_status_o <= 1'b0;
      end
      else
      begin
         if (state_r == DPS_DETECT && state_nxt == DPS_IDLE)
            status_hold_r <= pin1_s && pin2_s;
         else if (state_nxt != DPS_IDLE)
            status_hold_r <= 1'b0;
         path_one_closed_status_o <= (state_nxt == DPS_ON_ONE) || status_hold_r;
         path_two_closed_status_o <= (state_nxt == DPS_ON_TWO) || status_hold_r;
      end
   end

   // ***********************************************************
   // Register read
   // ***********************************************************
   // Read data is registered; unmapped offsets answer zero
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= DPS_RDATA_IDLE;
      else
      begin
         reg_rdata_o <= DPS_RDATA_IDLE;
         if (reg_rd_i && reg_addr_i == DPS_REG_PATH_CTRL)
         begin
            reg_rdata_o[DPS_BIT_EN_ONE]  <= en1_r;
            reg_rdata_o[DPS_BIT_EN_TWO]  <= en2_r;
            reg_rdata_o[DPS_BIT_ST_ONE]  <= path_one_closed_status_o;
            reg_rdata_o[DPS_BIT_ST_TWO]  <= path_two_closed_status_o;
            reg_rdata_o[DPS_BIT_ALL_DIS] <= dis_r;
         end
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   property p_never_both_closed;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !(gate_drive_one_o && gate_drive_two_o);
   endproperty
   a_never_both_closed: assert property (p_never_both_closed)
      else $error("both gate drives on");

   property p_disable_opens;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      dis_r |=> !gate_drive_one_o && !gate_drive_two_o;
   endproperty
   a_disable_opens: assert property (p_disable_opens)
      else $error("gate on after all-paths disable");

   property p_enable_gates;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !en1_r |=> !gate_drive_one_o;
   endproperty
   a_enable_gates: assert property (p_enable_gates)
      else $error("gate one on with enable clear");

   property p_no_pairs;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      det_done && $past(det_done) && !fitted1_r && !fitted2_r |-> dis_r && !en1_r && !en2_r;
   endproperty
   a_no_pairs: assert property (p_no_pairs)
      else $error("no-pair lock-out broken");

   property p_pair_two_absent;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      det_done && !fitted2_r |-> !en2_r && !path_two_closed_status_o && !gate_drive_two_oe_o;
   endproperty
   a_pair_two_absent: assert property (p_pair_two_absent)
      else $error("absent pair two not locked");

   property p_turn_on_cond;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(gate_drive_one_o) |-> $past(!conv_s && v1 && !block);
   endproperty
   a_turn_on_cond: assert property (p_turn_on_cond)
      else $error("gate one closed without its conditions");

   property p_status_tracks;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      gate_drive_one_o |-> path_one_closed_status_o;
   endproperty
   a_status_tracks: assert property (p_status_tracks)
      else $error("status one low while closed");

   property p_zero_write_one_valid;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      det_done && wr_ctrl && !w_en1 && !w_en2 && !reg_wdata_i[DPS_BIT_ALL_DIS] && (v1 ^ v2)
      |=> (en1_r || en2_r || !$past(en1_r || en2_r));
   endproperty
   a_zero_write_one_valid: assert property (p_zero_write_one_valid)
      else $error("00 write honoured with one valid input");

   property p_break_before_make;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $fell(gate_drive_one_o) |-> !gate_drive_two_o ##1 !gate_drive_two_o;
   endproperty
   a_break_before_make: assert property (p_break_before_make)
      else $error("pair two closed right after pair one opened");

endmodule : dps_path_selector

/* File: sim/dps_far_side.sv */
// Far-side model: the external FET pairs on the gate pins and the converter node.
// Assumes fitted gate pins carry a pull-up and absent ones are strapped to ground.
`timescale 1ns/10ps
module dps_far_side #(
   parameter int DROP = 6  // Cycles the converter node takes to decay below presence
) (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   // Board configuration and sources
   input  wire logic fit_one_i,
   input  wire logic fit_two_i,
   input  wire logic in_one_i,
   input  wire logic in_two_i,
   input  wire logic direct_src_i,
   // Gate drive from the selector
   input  wire logic gate_one_drv_i,
   input  wire logic gate_one_oe_i,
   input  wire logic gate_two_drv_i,
   input  wire logic gate_two_oe_i,
   // Observed levels
   output logic      gate_one_pin_o,
   output logic      gate_two_pin_o,
   output logic      conv_present_o
);
   logic [3:0] decay_r;
   logic       feed;

   // Released pin shows its strap: pull-up when fitted, ground when absent
   assign gate_one_pin_o = gate_one_oe_i ? gate_one_drv_i : fit_one_i;
   assign gate_two_pin_o = gate_two_oe_i ? gate_two_drv_i : fit_two_i;

   // Node is fed by a closed pair with a live source, or by the direct source
   assign feed = (gate_one_oe_i & gate_one_drv_i & in_one_i & fit_one_i)
               | (gate_two_oe_i & gate_two_drv_i & in_two_i & fit_two_i) | direct_src_i;

   // Bulk capacitance keeps the node up for a while, so a fast swap is caught
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
      if (!reset_n_i)
         decay_r <= 4'h0;
      else if (feed)
         decay_r <= 4'(DROP);
      else if (decay_r != 4'h0)
         decay_r <= decay_r - 4'h1;

   assign conv_present_o = feed | (decay_r != 4'h0);
endmodule : dps_far_side

/* File: sim/tb_dps_path_selector.sv */
// Testbench for the dual input power path selector.
// Assumes the far-side model for pins and converter; host accesses are driven here.
`timescale 1ns/10ps
module tb_dps_path_selector;
   import dps_pkg::*;
   logic            sys_clk, reset_n, reg_wr, reg_rd, one_p, one_ov, two_p, two_ov, oc_flt;
   logic            both_dis, hiz_req, fit_one, fit_two, direct_src, g1_q, g2_q, conv_q;
   logic [7:0]      reg_addr, reg_wdata;
   wire logic [7:0] reg_rdata;
   wire logic       g1_pin, g1_drv, g1_oe, g2_pin, g2_drv, g2_oe, st_one, st_two, conv_p;
   int              num_errors = 0;
   int              tests_run = 0;
   wire logic       g1_on = g1_oe & g1_drv;
   wire logic       g2_on = g2_oe & g2_drv;

   dps_path_selector dps_path_selector_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata), .input_sense_one_present_i(one_p), .input_sense_one_ov_i(one_ov),
      .input_sense_two_present_i(two_p), .input_sense_two_ov_i(two_ov),
      .converter_input_present_i(conv_p), .input_overcurrent_fault_i(oc_flt),
      .both_gates_disable_i(both_dis), .input_high_impedance_request_i(hiz_req),
      .gate_drive_one_i(g1_pin), .gate_drive_one_o(g1_drv), .gate_drive_one_oe_o(g1_oe),
      .gate_drive_two_i(g2_pin), .gate_drive_two_o(g2_drv), .gate_drive_two_oe_o(g2_oe),
      .path_one_closed_status_o(st_one), .path_two_closed_status_o(st_two));

   dps_far_side dps_far_side_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .fit_one_i(fit_one),
      .fit_two_i(fit_two), .in_one_i(one_p), .in_two_i(two_p), .direct_src_i(direct_src),
      .gate_one_drv_i(g1_drv), .gate_one_oe_i(g1_oe), .gate_two_drv_i(g2_drv), .gate_two_oe_i(g2_oe),
      .gate_one_pin_o(g1_pin), .gate_two_pin_o(g2_pin), .conv_present_o(conv_p));

   // ****************************************
   // Clock, monitors and helpers
   // ****************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Sampled on the falling edge so gate and node values are settled
   always @(negedge sys_clk)
   begin
      if (g1_on && g2_on) chk("both gates closed", 8'h00, 8'h01);
      if (((g1_on && !g1_q) || (g2_on && !g2_q)) && conv_q) chk("gate closed on live node", 8'h00, 8'h01);
      g1_q = g1_on;
      g2_q = g2_on;
      conv_q = conv_p;
   end

   function automatic logic [7:0] fld(input logic e1, e2, s1, s2, dis);
      fld = 8'h00;
      fld[DPS_BIT_EN_ONE] = e1;
      fld[DPS_BIT_EN_TWO] = e2;
      fld[DPS_BIT_ST_ONE] = s1;
      fld[DPS_BIT_ST_TWO] = s2;
      fld[DPS_BIT_ALL_DIS] = dis;
   endfunction : fld

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr_reg(input logic [7:0] d);
      reg_addr = DPS_REG_PATH_CTRL;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);  // Let an edge pass so a following strobe never toggles in the same step
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input string what, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      chk(what, exp, reg_rdata);
      tick(1);  // Read data stands one cycle only, so judge it before this idle edge
   endtask : rd_reg

   // Bounded wait for the gate pair to reach a level, then judge it
   task automatic wait_gates(input logic [1:0] exp, input string what);
      int n;
      n = 0;
      while ({g1_on, g2_on} !== exp && n < 60)
      begin
         tick(1);
         n++;
      end
      chk(what, {6'h00, exp}, {6'h00, g1_on, g2_on});
   endtask : wait_gates

   task automatic do_reset(input logic f1, input logic f2);
      reset_n = 1'b0;
      {reg_wr, reg_rd, one_p, one_ov, two_p, two_ov, oc_flt, both_dis, hiz_req, direct_src} = '0;
      reg_addr = DPS_REG_PATH_CTRL;
      reg_wdata = 8'h00;
      fit_one = f1;
      fit_two = f2;
      tick(4);
      reset_n = 1'b1;
      tick(120);  // Detection window plus pin synchroniser
   endtask : do_reset

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_no_pairs;
      do_reset(1'b0, 1'b0);
      {one_p, two_p, direct_src} = 3'b111;
      rd_reg(DPS_REG_PATH_CTRL, "no pairs reg", fld(0, 0, 0, 0, 1));
      wr_reg(fld(1, 0, 0, 0, 0));
      wr_reg(fld(0, 1, 0, 0, 0));
      rd_reg(DPS_REG_PATH_CTRL, "locked enables", fld(0, 0, 0, 0, 1));
      rd_reg(8'h12, "unmapped read", DPS_RDATA_IDLE);
      wait_gates(2'b00, "no pairs gates");
      $display("test no_pairs done");
   endtask : t_no_pairs

   task automatic t_one_pair;
      int n;
      do_reset(1'b1, 1'b0);
      rd_reg(DPS_REG_PATH_CTRL, "one pair reg", fld(0, 0, 0, 0, 0));
      one_p = 1'b1;
      wait_gates(2'b10, "auto close one");
      rd_reg(DPS_REG_PATH_CTRL, "one pair on", fld(1, 0, 1, 0, 0));
      chk("status one port", 8'h01, {7'h00, st_one});
      wr_reg(fld(0, 0, 0, 0, 1));
      wait_gates(2'b00, "disable opens");
      direct_src = 1'b1;
      tick(10);
      rd_reg(DPS_REG_PATH_CTRL, "disable clears en", fld(0, 0, 0, 0, 1));
      direct_src = 1'b0;
      n = 0;
      while (conv_p && n < 50)
      begin
         tick(1);
         n++;
      end
      wr_reg(fld(0, 0, 0, 0, 0));
      wait_gates(2'b10, "reclose one");
      rd_reg(DPS_REG_PATH_CTRL, "one pair back", fld(1, 0, 1, 0, 0));
      $display("test one_pair done");
   endtask : t_one_pair

   task automatic t_dual;
      do_reset(1'b1, 1'b1);
      rd_reg(DPS_REG_PATH_CTRL, "dual detect", fld(0, 0, 1, 1, 0));
      two_p = 1'b1;
      wait_gates(2'b01, "first valid two");
      wr_reg(fld(0, 0, 0, 0, 0));
      tick(10);
      rd_reg(DPS_REG_PATH_CTRL, "00 with one input", fld(0, 1, 0, 1, 0));
      one_p = 1'b1;
      tick(20);
      wait_gates(2'b01, "late input stays off");
      wr_reg(fld(1, 0, 0, 0, 0));
      wait_gates(2'b10, "manual swap");
      wr_reg(fld(1, 1, 0, 0, 0));
      tick(10);
      rd_reg(DPS_REG_PATH_CTRL, "both enables", fld(1, 0, 1, 0, 0));
      one_p = 1'b0;
      wait_gates(2'b01, "undervoltage swap");
      rd_reg(DPS_REG_PATH_CTRL, "uv enables", fld(0, 1, 0, 1, 0));
      one_p = 1'b1;
      tick(10);
      two_ov = 1'b1;
      wait_gates(2'b10, "overvoltage swap");
      rd_reg(DPS_REG_PATH_CTRL, "ov enables", fld(1, 0, 1, 0, 0));
      two_ov = 1'b0;
      tick(10);
      oc_flt = 1'b1;
      wait_gates(2'b00, "overcurrent opens");
      oc_flt = 1'b0;
      wait_gates(2'b01, "overcurrent swap");
      rd_reg(DPS_REG_PATH_CTRL, "oc enables", fld(0, 1, 0, 1, 0));
      wr_reg(fld(0, 0, 0, 0, 0));
      wait_gates(2'b00, "00 opens both");
      wr_reg(fld(1, 0, 0, 0, 0));
      wait_gates(2'b10, "enable one again");
      wr_reg(fld(0, 0, 0, 0, 1));
      wait_gates(2'b00, "disable opens both");
      rd_reg(DPS_REG_PATH_CTRL, "dual disabled", fld(0, 0, 0, 0, 1));
      $display("test dual done");
   endtask : t_dual

   task automatic t_simul;
      do_reset(1'b1, 1'b1);
      {one_p, two_p} = 2'b11;
      wait_gates(2'b10, "simultaneous inputs");
      tick(5);
      rd_reg(DPS_REG_PATH_CTRL, "priority one", fld(1, 0, 1, 0, 0));
      both_dis = 1'b1;
      wait_gates(2'b00, "both disable blocks");
      both_dis = 1'b0;
      wait_gates(2'b10, "block released");
      hiz_req = 1'b1;
      wait_gates(2'b00, "high impedance blocks");
      hiz_req = 1'b0;
      wait_gates(2'b10, "hiz released");
      $display("test simul done");
   endtask : t_simul

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Whole run is under two thousand cycles; this span of 20000 cycles is ten times that
   initial
   begin
      #200000;
      num_errors++;
      complete_run();
   end

   initial
   begin
      {g1_q, g2_q, conv_q} = 3'b000;
      t_no_pairs();
      t_one_pair();
      t_dual();
      t_simul();
      complete_run();
   end
endmodule : tb_dps_path_selector
